// ---- pkg/flash_param_pkg.sv ----
// Constants and types for the flash program and erase parameter checker.
package flash_param_pkg;
  localparam int unsigned   PROGRAM_BYTES   = 128;
  localparam int unsigned   ALIGN_BITS      = 7;
  localparam logic [6:0]    LAST_BYTE_INDEX = 7'h7f;
  localparam logic [31:0]   FLASH_FIRST     = 32'h0000_0000;
  localparam logic [31:0]   FLASH_LAST      = 32'h0003_ffff;
  localparam logic [31:0]   LAST_BLOCK      = 32'h0000_000b;
  localparam logic [7:0]    KEY_VALID       = 8'h5a;
  localparam int unsigned   FREQ_MSB        = 15;
  localparam int unsigned   RES_FAIL_BIT    = 0;
  localparam int unsigned   RES_SRC_ERR_BIT = 1;
  localparam int unsigned   RES_DST_ERR_BIT = 2;
  localparam int unsigned   RES_BLK_ERR_BIT = 3;
  localparam int unsigned   RES_KEY_ERR_BIT = 4;
  localparam logic [31:0]   RESULT_RESET    = 32'h0000_0000;
  localparam logic [15:0]   FREQ_RESET      = 16'h0000;
  localparam logic [31:0]   ADDR_RESET      = 32'h0000_0000;
  localparam logic [7:0]    DATA_RESET      = 8'h00;
  localparam logic [6:0]    COUNT_RESET     = 7'h00;
  localparam logic [3:0]    BLOCK_RESET     = 4'h0;
  localparam int unsigned   COPY_CYCLES     = 257;

  typedef enum logic [0:0] {OP_IDLE, OP_COPY} op_state_t;
  typedef enum logic [1:0] {CP_IDLE, CP_READ, CP_CAPTURE} copy_state_t;
endpackage

// ---- pkg/copy_if.sv ----
// Handshake between the parameter checker and the block copier.
`timescale 1ns/1ps
interface copy_if;
  logic        go;
  logic [31:0] src;
  logic [31:0] dst;
  logic        done;
  modport ctrl (output go, output src, output dst, input done);
  modport copier (input go, input src, input dst, output done);
endinterface

// ---- logic/block_copier.sv ----
// Copies one 128-byte block from source memory into the user array.
`timescale 1ns/1ps
module block_copier (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // Control handshake
  copy_if.copier           cp,
  // Memory ports
  output logic             mem_rd_en,
  output logic [31:0]      mem_rd_addr,
  input  wire logic [7:0]  mem_rd_data,
  output logic             mem_wr_en,
  output logic [31:0]      mem_wr_addr,
  output logic [7:0]       mem_wr_data
);
  import flash_param_pkg::*;

  copy_state_t state_reg, state_next;
  logic [6:0]  count_reg, count_next;
  logic [6:0]  count_inc;
  logic [31:0] src_reg, src_next;
  logic [31:0] dst_reg, dst_next;
  logic        rd_en_reg, rd_en_next;
  logic [31:0] rd_addr_reg, rd_addr_next;
  logic        wr_en_reg, wr_en_next;
  logic [31:0] wr_addr_reg, wr_addr_next;
  logic [7:0]  wr_data_reg, wr_data_next;
  logic        done_reg, done_next;

  assign count_inc = count_reg + 7'h01;

  always_comb begin
    state_next   = state_reg;
    count_next   = count_reg;
    src_next     = src_reg;
    dst_next     = dst_reg;
    rd_en_next   = 1'b0;
    rd_addr_next = rd_addr_reg;
    wr_en_next   = 1'b0;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    done_next    = 1'b0;
    case (state_reg)
      CP_IDLE: begin
        if (cp.go) begin
          src_next     = cp.src;
          dst_next     = cp.dst;
          count_next   = COUNT_RESET;
          rd_en_next   = 1'b1;
          rd_addr_next = cp.src;
          state_next   = CP_READ;
        end
      end
      CP_READ: begin
        state_next = CP_CAPTURE;
      end
      CP_CAPTURE: begin
        // Data is valid the cycle after the read strobe was seen.
        wr_en_next   = 1'b1;
        wr_addr_next = {dst_reg[31:ALIGN_BITS], count_reg};
        wr_data_next = mem_rd_data;
        if (count_reg == LAST_BYTE_INDEX) begin
          done_next  = 1'b1;
          state_next = CP_IDLE;
        end else begin
          count_next   = count_inc;
          rd_en_next   = 1'b1;
          rd_addr_next = src_reg + {25'h0, count_inc};
          state_next   = CP_READ;
        end
      end
      default: begin
        state_next = CP_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_reg   <= CP_IDLE;
      count_reg   <= COUNT_RESET;
      src_reg     <= ADDR_RESET;
      dst_reg     <= ADDR_RESET;
      rd_en_reg   <= 1'b0;
      rd_addr_reg <= ADDR_RESET;
      wr_en_reg   <= 1'b0;
      wr_addr_reg <= ADDR_RESET;
      wr_data_reg <= DATA_RESET;
      done_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      count_reg   <= count_next;
      src_reg     <= src_next;
      dst_reg     <= dst_next;
      rd_en_reg   <= rd_en_next;
      rd_addr_reg <= rd_addr_next;
      wr_en_reg   <= wr_en_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
      done_reg    <= done_next;
    end
  end

  assign mem_rd_en   = rd_en_reg;
  assign mem_rd_addr = rd_addr_reg;
  assign mem_wr_en   = wr_en_reg;
  assign mem_wr_addr = wr_addr_reg;
  assign mem_wr_data = wr_data_reg;
  assign cp.done     = done_reg;

  a_copy_length: assert property (
    @(posedge CLOCK) disable iff (RST)
    (state_reg == CP_IDLE && cp.go) |-> ##257 done_reg)
    else $error("Block copy did not finish after 128 bytes.");

  a_write_in_block: assert property (
    @(posedge CLOCK) disable iff (RST)
    wr_en_reg |-> (wr_addr_reg[31:ALIGN_BITS] == dst_reg[31:ALIGN_BITS]))
    else $error("Write left the 128-byte destination block.");

  a_write_data_src: assert property (
    @(posedge CLOCK) disable iff (RST)
    rd_en_reg |=> ##1 (wr_en_reg && wr_data_reg == $past(mem_rd_data)))
    else $error("Written byte differs from the byte fetched.");

  a_read_stride: assert property (
    @(posedge CLOCK) disable iff (RST)
    (rd_en_reg && state_reg == CP_READ) |->
      (rd_addr_reg == src_reg + {25'h0, count_reg}))
    else $error("Source fetch address out of sequence.");
endmodule // block_copier

// ---- logic/flash_param_checker.sv ----
// Parameter checker and launcher for flash block program and erase.
`timescale 1ns/1ps
module flash_param_checker (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // Operation requests with CPU general register contents
  input  wire logic        INIT_START,
  input  wire logic        PROG_START,
  input  wire logic        ERASE_START,
  input  wire logic [31:0] CPU_GENERAL_REG_0,
  input  wire logic [31:0] CPU_GENERAL_REG_1,
  input  wire logic [7:0]  FLASH_KEY_REGISTER,
  // Results
  output logic [31:0]      PROGRAM_RESULT_WORD,
  output logic [15:0]      FREQUENCY_VALUE_BITS,
  output logic             BUSY,
  output logic             DONE,
  // Memory array ports
  output logic             MEM_RD_EN,
  output logic [31:0]      MEM_RD_ADDR,
  input  wire logic [7:0]  MEM_RD_DATA,
  output logic             MEM_WR_EN,
  output logic [31:0]      MEM_WR_ADDR,
  output logic [7:0]       MEM_WR_DATA,
  output logic             ERASE_STROBE,
  output logic [3:0]       ERASE_BLOCK
);
  import flash_param_pkg::*;

  copy_if cp ();

  op_state_t   state_reg, state_next;
  logic [31:0] result_reg, result_next;
  logic [15:0] freq_reg, freq_next;
  logic        busy_reg, busy_next;
  logic        done_reg, done_next;
  logic        erase_reg, erase_next;
  logic [3:0]  block_reg, block_next;
  logic        go_c;
  logic        dst_outside, dst_unaligned, dst_error;
  logic        src_error, blk_error, key_error;
  logic [31:0] dst_word, src_word;

  // Program takes its destination in reg 1 and its source in reg 0.
  assign dst_word      = CPU_GENERAL_REG_1;
  assign src_word      = CPU_GENERAL_REG_0;
  assign dst_outside   = (dst_word < FLASH_FIRST) ||
                         (dst_word > FLASH_LAST);
  assign dst_unaligned = (dst_word[ALIGN_BITS-1:0] != 7'h00);
  assign dst_error     = dst_outside || dst_unaligned;
  assign src_error     = (src_word >= FLASH_FIRST) &&
                         (src_word <= FLASH_LAST);
  assign blk_error     = (CPU_GENERAL_REG_0 > LAST_BLOCK);
  assign key_error     = (FLASH_KEY_REGISTER != KEY_VALID);

  always_comb begin
    state_next  = state_reg;
    result_next = result_reg;
    freq_next   = freq_reg;
    busy_next   = busy_reg;
    done_next   = 1'b0;
    erase_next  = 1'b0;
    block_next  = block_reg;
    go_c        = 1'b0;
    case (state_reg)
      OP_IDLE: begin
        // Program wins over erase, erase over frequency setup.
        if (PROG_START) begin
          result_next = RESULT_RESET;
          result_next[RES_DST_ERR_BIT] = dst_error;
          result_next[RES_SRC_ERR_BIT] = src_error;
          result_next[RES_FAIL_BIT]    = dst_error || src_error;
          if (dst_error || src_error) begin
            done_next = 1'b1;
          end else begin
            go_c       = 1'b1;
            busy_next  = 1'b1;
            state_next = OP_COPY;
          end
        end else if (ERASE_START) begin
          result_next = RESULT_RESET;
          result_next[RES_BLK_ERR_BIT] = blk_error;
          result_next[RES_KEY_ERR_BIT] = key_error;
          result_next[RES_FAIL_BIT]    = blk_error || key_error;
          done_next = 1'b1;
          if (!blk_error && !key_error) begin
            erase_next = 1'b1;
            block_next = CPU_GENERAL_REG_0[3:0];
          end
        end else if (INIT_START) begin
          // Upper half is ignored; a caller that breaks this loses nothing.
          freq_next = CPU_GENERAL_REG_0[FREQ_MSB:0];
          done_next = 1'b1;
        end
      end
      OP_COPY: begin
        if (cp.done) begin
          busy_next  = 1'b0;
          done_next  = 1'b1;
          state_next = OP_IDLE;
        end
      end
      default: begin
        state_next = OP_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_reg  <= OP_IDLE;
      result_reg <= RESULT_RESET;
      freq_reg   <= FREQ_RESET;
      busy_reg   <= 1'b0;
      done_reg   <= 1'b0;
      erase_reg  <= 1'b0;
      block_reg  <= BLOCK_RESET;
    end else begin
      state_reg  <= state_next;
      result_reg <= result_next;
      freq_reg   <= freq_next;
      busy_reg   <= busy_next;
      done_reg   <= done_next;
      erase_reg  <= erase_next;
      block_reg  <= block_next;
    end
  end

  assign cp.go  = go_c;
  assign cp.src = src_word;
  assign cp.dst = dst_word;

  block_copier u_copier (
    .CLOCK       (CLOCK),
    .RST         (RST),
    .cp          (cp.copier),
    .mem_rd_en   (MEM_RD_EN),
    .mem_rd_addr (MEM_RD_ADDR),
    .mem_rd_data (MEM_RD_DATA),
    .mem_wr_en   (MEM_WR_EN),
    .mem_wr_addr (MEM_WR_ADDR),
    .mem_wr_data (MEM_WR_DATA)
  );

  assign PROGRAM_RESULT_WORD  = result_reg;
  assign FREQUENCY_VALUE_BITS = freq_reg;
  assign BUSY                 = busy_reg;
  assign DONE                 = done_reg;
  assign ERASE_STROBE         = erase_reg;
  assign ERASE_BLOCK          = block_reg;

  a_dest_align_err: assert property (
    @(posedge CLOCK) disable iff (RST)
    (state_reg == OP_IDLE && PROG_START && dst_word[6:0] != 7'h00) |=>
      (PROGRAM_RESULT_WORD[RES_DST_ERR_BIT] && DONE && !BUSY))
    else $error("Unaligned destination not flagged.");

  a_dest_range_err: assert property (
    @(posedge CLOCK) disable iff (RST)
    (state_reg == OP_IDLE && PROG_START && dst_word > FLASH_LAST) |=>
      PROGRAM_RESULT_WORD[RES_DST_ERR_BIT])
    else $error("Destination outside flash not flagged.");

  a_src_flash_err: assert property (
    @(posedge CLOCK) disable iff (RST)
    (state_reg == OP_IDLE && PROG_START && src_word <= FLASH_LAST) |=>
      (PROGRAM_RESULT_WORD[RES_SRC_ERR_BIT] &&
       PROGRAM_RESULT_WORD[RES_FAIL_BIT]))
    else $error("Source inside flash not flagged.");

  a_block_range: assert property (
    @(posedge CLOCK) disable iff (RST)
    (state_reg == OP_IDLE && !PROG_START && ERASE_START) |=>
      (PROGRAM_RESULT_WORD[3] == ($past(CPU_GENERAL_REG_0) > 32'h0000_000b)))
    else $error("Erase block error bit wrong.");

  a_key_check: assert property (
    @(posedge CLOCK) disable iff (RST)
    (state_reg == OP_IDLE && !PROG_START && ERASE_START &&
     FLASH_KEY_REGISTER != 8'h5a) |=>
      (PROGRAM_RESULT_WORD[RES_KEY_ERR_BIT] && !ERASE_STROBE))
    else $error("Bad key not flagged or erase started.");

  a_no_op_on_err: assert property (
    @(posedge CLOCK) disable iff (RST)
    (PROGRAM_RESULT_WORD[RES_FAIL_BIT] && DONE) |->
      (!ERASE_STROBE && !MEM_WR_EN && !BUSY))
    else $error("Operation started despite a parameter error.");

  a_erase_block_sel: assert property (
    @(posedge CLOCK) disable iff (RST)
    ERASE_STROBE |-> (ERASE_BLOCK <= 4'hb && !PROGRAM_RESULT_WORD[0]))
    else $error("Erase issued for an invalid block.");

  a_freq_capture: assert property (
    @(posedge CLOCK) disable iff (RST)
    (state_reg == OP_IDLE && !PROG_START && !ERASE_START && INIT_START) |=>
      (FREQUENCY_VALUE_BITS == $past(CPU_GENERAL_REG_0[15:0])))
    else $error("Frequency field not captured from low half.");

  a_prog_done: assert property (
    @(posedge CLOCK) disable iff (RST)
    (state_reg == OP_IDLE && PROG_START && !dst_error && !src_error) |->
      ##1 BUSY ##256 (BUSY && !DONE) ##1 (DONE && !BUSY))
    else $error("Program did not complete in 258 cycles.");
endmodule // flash_param_checker

// ---- verif/mem_model.sv ----
// Source memory model that answers the block's byte reads one cycle later.
`timescale 1ns/1ps
module mem_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Read port
  input  wire logic        rd_en,
  input  wire logic [31:0] rd_addr,
  output logic [7:0]       rd_data
);
  // Outside its one valid cycle the data is inverted every cycle.
  // A capture taken a cycle late then shows up as wrong data.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      rd_data <= rd_addr[7:0] ^ rd_addr[15:8] ^ 8'h3c;
    end else begin
      rd_data <= ~rd_data;
    end
  end
endmodule // mem_model

// ---- verif/tb.sv ----
// Self-checking bench for the flash parameter checker.
`timescale 1ns/1ps
module tb;
  logic        clock;
  logic        rst;
  logic        init_start, prog_start, erase_start;
  logic [31:0] reg0, reg1, result, rd_addr, wr_addr, exp_src, exp_dst;
  logic [7:0]  key, rd_data, wr_data;
  logic [15:0] freq;
  logic [3:0]  blk;
  logic        busy, done, rd_en, wr_en, strobe;
  logic [15:0] freqs [3] = '{16'h0320, 16'h0ce4, 16'h12c0};
  int          failures, checked, wr_cnt, st_cnt;

  flash_param_checker u_dut (
    .CLOCK(clock), .RST(rst), .INIT_START(init_start),
    .PROG_START(prog_start), .ERASE_START(erase_start),
    .CPU_GENERAL_REG_0(reg0), .CPU_GENERAL_REG_1(reg1),
    .FLASH_KEY_REGISTER(key), .PROGRAM_RESULT_WORD(result),
    .FREQUENCY_VALUE_BITS(freq), .BUSY(busy), .DONE(done),
    .MEM_RD_EN(rd_en), .MEM_RD_ADDR(rd_addr), .MEM_RD_DATA(rd_data),
    .MEM_WR_EN(wr_en), .MEM_WR_ADDR(wr_addr), .MEM_WR_DATA(wr_data),
    .ERASE_STROBE(strobe), .ERASE_BLOCK(blk));

  mem_model u_mem (.clock(clock), .rst(rst), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data));

  function automatic logic [7:0] pat(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude;
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Every write and erase strobe is judged as it happens.
  always @(posedge clock) begin
    if (wr_en === 1'b1) begin
      check("write address", exp_dst + wr_cnt, wr_addr);
      check("write data", pat(exp_src + wr_cnt), wr_data);
      wr_cnt++;
    end
    if (strobe === 1'b1) begin
      check("erase block", exp_src[3:0], blk);
      st_cnt++;
    end
  end

  // One request: kind bit 0 program, bit 1 erase, bit 2 frequency setup.
  task automatic op(input logic [2:0] kind, input logic [31:0] r0, r1,
                    input logic [7:0] k, input int lat,
                    input logic [31:0] res, input int wr_exp, st_exp,
                    input logic poke);
    int n;
    n = 0;
    wr_cnt = 0;
    st_cnt = 0;
    exp_src = r0;
    exp_dst = r1;
    @(posedge clock);
    {init_start, erase_start, prog_start} <= kind;
    reg0 <= r0;
    reg1 <= r1;
    key <= k;
    @(posedge clock);
    {init_start, erase_start, prog_start} <= 3'b000;
    // Done stands one cycle only, so it is looked at right after each edge.
    #1;
    n = 1;
    if (lat > 1) check("busy", 32'h1, busy);
    while (done !== 1'b1 && n < 300) begin
      @(posedge clock);
      // A valid erase offered while busy must be ignored.
      if (poke && n == 8) begin
        erase_start <= 1'b1;
        reg0 <= 32'h0000_0002;
      end else begin
        erase_start <= 1'b0;
      end
      n++;
      #1;
    end
    check("latency", lat, n);
    check("result", res, result);
    check("busy after done", 32'h0, busy);
    @(posedge clock);
    #1;
    check("write count", wr_exp, wr_cnt);
    check("strobe count", st_exp, st_cnt);
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    {init_start, prog_start, erase_start} = 3'b000;
    reg0 = 32'h0;
    reg1 = 32'h0;
    key = 8'h5a;
    failures = 0;
    checked = 0;
    wr_cnt = 0;
    st_cnt = 0;
    exp_src = 32'h0;
    exp_dst = 32'h0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    check("reset result", 32'h0, result);
    check("reset frequency", 32'h0, freq);
    check("reset busy done", 32'h0, {busy, done});
    // Words for 8, 33 and 48 MHz; 48 MHz stands for 12 MHz times 4.
    foreach (freqs[i]) begin
      op(3'b100, {16'h0, freqs[i]}, 0, 8'h5a, 1, 0, 0, 0,
         0);
      check("frequency", freqs[i], freq);
    end
    op(3'b001, 32'h0004_0000, 32'h0000_1040, 8'h5a, 1, 5, 0, 0, 0);
    op(3'b001, 32'h0004_0000, 32'h0004_0000, 8'h5a, 1, 5, 0, 0, 0);
    op(3'b001, 32'h0003_ff80, 32'h0000_1000, 8'h5a, 1, 3, 0, 0, 0);
    op(3'b001, 32'h0000_0000, 32'h0000_0001, 8'h5a, 1, 7, 0, 0, 0);
    // Frequency setup leaves the last result in place.
    op(3'b100, 32'h0000_0ce4, 0, 8'h5a, 1, 7, 0, 0, 0);
    op(3'b001, 32'h0004_0000, 32'h0000_1080, 8'h5a, 258, 0, 128, 0,
       1);
    op(3'b001, 32'h0004_1234, 32'h0003_ff80, 8'h5a, 258, 0, 128, 0,
       0);
    for (int b = 0; b < 12; b++) begin
      op(3'b010, b, 0, 8'h5a, 1, 0, 0, 1, 0);
    end
    op(3'b010, 32'h0000_000c, 0, 8'h5a, 1, 32'h09, 0, 0, 0);
    op(3'b010, 32'h0001_0000, 0, 8'h5a, 1, 32'h09, 0, 0, 0);
    op(3'b010, 32'h0000_0003, 0, 8'ha5, 1, 32'h11, 0, 0, 0);
    op(3'b010, 32'hffff_ffff, 0, 8'h00, 1, 32'h19, 0, 0, 0);
    conclude();
  end
endmodule // tb
